// file: host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side master for both serial modes
module host_bus_model (
   input  wire logic mclk_i,   // core clock paces two-wire bits
   input  wire logic sda_oe_i, // device pulls data low
   input  wire logic sdo_i,    // four-wire data from device
   output logic      sclk_o,   // serial clock pin
   output logic      sel_o,    // select or address strap
   output logic      sdi_o,    // four-wire data to device
   output logic      sda_o     // resolved two-wire data line
);
   logic sda_h;

   // pulled-up line, low when either side pulls
   assign sda_o = sda_h & ~sda_oe_i;

   // idle bus, clock stands still outside frames
   initial begin
      sclk_o = 1'b0;
      sel_o = 1'b1;
      sdi_o = 1'b0;
      sda_h = 1'b1;
   end

   task automatic hw(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic strap(input logic v, input logic clk);
      sel_o = v;
      sclk_o = clk;
   endtask

   // free clock pulses with data released, to clear a stuck acknowledge
   task automatic pulses(input int n);
      repeat (n) begin
         hw(6);
         sclk_o = 1'b0;
         hw(6);
         sclk_o = 1'b1;
      end
      hw(6);
   endtask

   // one two-wire bit; r is the line level while clock is high
   task automatic bit2(input logic b, output logic r);
      hw(1);
      sda_h = b;
      hw(5);
      sclk_o = 1'b1;
      hw(3);
      r = sda_o;
      hw(3);
      sclk_o = 1'b0;
   endtask

   // framed two-wire transfer; nak set when an acknowledge is missing
   task automatic i2c(input logic [7:0] a, input logic [7:0] c,
                      output logic nak, output logic [23:0] rd);
      logic r;
      rd = '0;
      sda_h = 1'b1;
      sclk_o = 1'b1;
      hw(6);
      sda_h = 1'b0;
      hw(6);
      sclk_o = 1'b0;
      for (int i = 7; i >= 0; i--) bit2(a[i], r);
      bit2(1'b1, r);
      nak = r;
      if (!nak && !a[0]) begin
         for (int i = 7; i >= 0; i--) bit2(c[i], r);
         bit2(1'b1, r);
         nak = r;
      end else if (!nak) begin
         for (int k = 0; k < 24; k++) begin
            bit2(1'b1, r);
            rd = {rd[22:0], r};
            if (k % 8 == 7) bit2(k == 23, r);
         end
      end
      hw(1);
      sda_h = 1'b0;
      hw(5);
      sclk_o = 1'b1;
      hw(6);
      sda_h = 1'b1;
      hw(6);
   endtask

   // four-wire mode 0 frame; filler bits toggle after the command
   task automatic spi(input logic [7:0] c, input int n,
                      output logic [23:0] rd);
      rd = '0;
      sel_o = 1'b0;
      #50;
      for (int i = 0; i < n; i++) begin
         sdi_o = (i < 8) ? c[7 - i] : ~sdi_o;
         #40;
         sclk_o = 1'b1;
         if (i >= 8) rd = {rd[22:0], sdo_i};
         #40;
         sclk_o = 1'b0;
      end
      #40;
      sel_o = 1'b1;
      #400;
   endtask
endmodule
`default_nettype wire

// file: sensor_cmd_pkg.sv
`default_nettype none
package sensor_cmd_pkg;
   // one-byte command codes shared by both serial modes
   localparam logic [7:0] CMD_RESET    = 8'h1E;
   localparam logic [7:0] CMD_ADC_READ = 8'h00;
   localparam logic [3:0] CONV_P_HI    = 4'h4;
   localparam logic [3:0] CONV_T_HI    = 4'h5;
   localparam logic [2:0] OSR_MAX      = 3'h4;         // select 4 = 4096
   localparam logic [3:0] CALIBRATION_MEMORY_HI      = 4'hA;
   localparam logic [5:0] I2C_ADDR_HI  = 6'h3B;        // 111011 upper bits
   localparam int         CAL_WORDS    = 8;
   localparam int         RES_BITS     = 24;
   localparam int         I2C_BYTE     = 8;
   // conversion time at the lowest ratio, doubled per select step
   localparam int         CONV_BASE_US = 100;
   localparam int         MCLK_MHZ     = 10;
   localparam int         CONV_BASE_CYC = CONV_BASE_US * MCLK_MHZ;
   // plain calibration pattern loaded by the reset command
   localparam logic [127:0] CAL_DEFAULT =
      128'h0007_0006_0005_0004_0003_0002_0001_0000;

   typedef enum logic [0:0] {
      CONV_IDLE = 1'b0,
      CONV_BUSY = 1'b1
   } conv_state_t;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_RX   = 3'b001,
      I2C_ACK  = 3'b010,
      I2C_TX   = 3'b011,
      I2C_RACK = 3'b100
   } i2c_state_t;

   typedef struct packed {
      logic       rst;
      logic       rd;
      logic       conv;
      logic       calibration_memory;
      logic       temp;
      logic [2:0] sel;   // ratio select or memory word address
   } cmd_dec_t;

   // decode a command byte; anything else decodes to no action
   function automatic cmd_dec_t cmd_decode(input logic [7:0] b);
      cmd_dec_t d;
      d.rst  = (b == CMD_RESET);
      d.rd   = (b == CMD_ADC_READ);
      d.conv = (b[7:4] == CONV_P_HI || b[7:4] == CONV_T_HI) && !b[0]
               && (b[3:1] <= OSR_MAX);
      d.calibration_memory = (b[7:4] == CALIBRATION_MEMORY_HI) && !b[0];
      d.temp = b[4];
      d.sel  = b[3:1];
      return d;
   endfunction
endpackage
`default_nettype wire

// file: sensor_serial_command_port.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - answer address 111011 plus inverse of select/address pin.
// - reset command acts at any time, aborting any operation.
// - accepted conversion keeps device busy until it completes.
// - read after result command returns the 24-bit result.
// - two-wire read-back has an acknowledge after every byte.
// - two-wire memory read is a command write then a separate read.
// - conversion keeps running while four-wire select is released.
// - result is shifted out most significant bit first.
// - result read gives zero when no new conversion finished.
// - result read during conversion gives zero and spoils result.
// - calibration memory is eight 16-bit words.
// - memory read returns one 16-bit word, MSB first.
// - two-wire conversion starts on a write of address then command byte.
// - both serial modes share one command set.
// - reset code is 1E hex, result read code is 00 hex.
// - conversion codes 40-48 pressure, 50-58 temperature.
// - memory read codes A0-AE, address in bits one to three.
// - pin high gives address 76 hex, pin low gives 77 hex.
module sensor_serial_command_port #(
   parameter int unsigned   CONV_BASE = sensor_cmd_pkg::CONV_BASE_CYC,
   parameter logic [127:0]  CAL_INIT  = sensor_cmd_pkg::CAL_DEFAULT
) (
   input  wire logic        mclk_i,                   // core clock
   input  wire logic        rst_b_i,                  // async reset
   input  wire logic        sclk_i,                   // serial clock pin
   input  wire logic        proto_i2c_i,              // 1 two-wire mode
   input  wire logic        select_or_address_pin_i,  // select / address
   input  wire logic        sdi_i,                    // four-wire data in
   output logic             sdo_o,                    // four-wire data out
   output logic             sdo_oe_o,                 // sdo drive enable
   input  wire logic        sda_i,                    // two-wire data in
   output logic             sda_o,                    // two-wire data out
   output logic             sda_oe_o,                 // pull sda low
   input  wire logic [23:0] raw_pressure_sample_i,    // analogue result
   input  wire logic [23:0] raw_temperature_sample_i, // analogue result
   output logic             busy_o,                   // conversion running
   output logic             cal_loaded_o              // calibration loaded
);
   import sensor_cmd_pkg::*;

   // core state
   conv_state_t             conv_reg, conv_next;
   logic [14:0]             ccnt_reg, ccnt_next;
   logic                    temp_reg, temp_next;
   logic                    bad_reg, bad_next;
   logic                    fresh_reg, fresh_next;
   logic                    calok_reg, calok_next;
   logic [RES_BITS-1:0]     result_reg, result_next;
   logic [RES_BITS-1:0]     pay_reg, pay_next;
   logic [RES_BITS-1:0]     pub_reg, pub_next;
   logic [15:0]             cal_reg [CAL_WORDS];
   logic [15:0]             cal_next [CAL_WORDS];
   // link side state
   logic [5:0]              scnt_reg, scnt_next;
   logic [7:0]              ssh_reg, ssh_next;
   logic [RES_BITS-1:0]     stx_reg, stx_next;
   logic [7:0]              scmd_reg, scmd_next;
   logic                    stgl_reg, stgl_next;
   logic                    sdo_reg;
   logic [7:0]              sbyte;
   cmd_dec_t                sdec;
   logic                    spi_arst_b;
   // synchronisers: scl sda proto toggle addrpin
   logic [4:0]              sy1_reg, sy2_reg, sy3_reg;
   // two-wire engine
   i2c_state_t              ist_reg, ist_next;
   logic [3:0]              icnt_reg, icnt_next;
   logic [7:0]              ish_reg, ish_next;
   logic                    ifirst_reg, ifirst_next;
   logic                    irw_reg, irw_next;
   logic                    ioe_reg, ioe_next;
   logic [RES_BITS-1:0]     itx_reg, itx_next;
   logic                    i2c_cmd_v;
   logic                    scl_s, sda_s, prot_s, apin_s;
   logic                    scl_rise, scl_fall, bus_start, bus_stop;
   logic                    addr_hit;
   // command path
   logic                    spi_evt, cmd_v, conv_done;
   logic [7:0]              cmd_byte;
   logic [2:0]              cmd_sel;
   cmd_dec_t                dec;

   // four-wire logic: released select clears the frame state
   assign spi_arst_b = rst_b_i & ~proto_i2c_i & ~select_or_address_pin_i;
   assign sdo_oe_o   = ~proto_i2c_i & ~select_or_address_pin_i;
   assign sdo_o      = sdo_reg;

   // four-wire next state: first byte of a frame is the command
   always_comb begin
      sbyte     = {ssh_reg[6:0], sdi_i};
      sdec      = cmd_decode(sbyte);
      scnt_next = (scnt_reg == 6'h3F) ? scnt_reg : scnt_reg + 6'h01;
      ssh_next  = sbyte;
      scmd_next = scmd_reg;
      stgl_next = stgl_reg;
      stx_next  = {stx_reg[22:0], 1'b0};
      if (scnt_reg == 6'h07) begin
         scmd_next = sbyte;
         stgl_next = ~stgl_reg;
         if (sdec.rd) begin
            stx_next = pub_reg;
         end else if (sdec.calibration_memory) begin
            stx_next = {cal_reg[sdec.sel], 8'h00};
         end else begin
            stx_next = '0;
         end
      end
   end

   // frame registers, cleared while select is released
   always_ff @(posedge sclk_i or negedge spi_arst_b) begin
      if (!spi_arst_b) begin
         scnt_reg <= '0;
         ssh_reg  <= '0;
         stx_reg  <= '0;
      end else begin
         scnt_reg <= scnt_next;
         ssh_reg  <= ssh_next;
         stx_reg  <= stx_next;
      end
   end

   // command word and toggle survive the end of the frame
   always_ff @(posedge sclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scmd_reg <= '0;
         stgl_reg <= 1'b0;
      end else begin
         scmd_reg <= scmd_next;
         stgl_reg <= stgl_next;
      end
   end

   // output bit changes on the falling edge, sampled by host on rising
   always_ff @(negedge sclk_i or negedge spi_arst_b) begin
      if (!spi_arst_b) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= stx_reg[23];
      end
   end

   // pins and the link toggle enter the core clock through two flops;
   // toggle bit resets low like the link toggle, so no false command
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sy1_reg <= 5'h13;
         sy2_reg <= 5'h13;
         sy3_reg <= 5'h13;
      end else begin
         sy1_reg <= {select_or_address_pin_i, stgl_reg, proto_i2c_i,
                     sda_i, sclk_i};
         sy2_reg <= sy1_reg;
         sy3_reg <= sy2_reg;
      end
   end

   // bus events seen in the core clock
   assign scl_s     = sy2_reg[0];
   assign sda_s     = sy2_reg[1];
   assign prot_s    = sy2_reg[2];
   assign apin_s    = sy2_reg[4];
   assign spi_evt   = sy2_reg[3] ^ sy3_reg[3];
   assign scl_rise  = scl_s & ~sy3_reg[0];
   assign scl_fall  = ~scl_s & sy3_reg[0];
   assign bus_start = scl_s & sy3_reg[0] & sy3_reg[1] & ~sda_s;
   assign bus_stop  = scl_s & sy3_reg[0] & ~sy3_reg[1] & sda_s;
   assign addr_hit  = (ish_reg[7:1] == {I2C_ADDR_HI, ~apin_s});
   assign sda_o     = 1'b0;
   assign sda_oe_o  = ioe_reg;

   // two-wire engine next state
   always_comb begin
      ist_next    = ist_reg;
      icnt_next   = icnt_reg;
      ish_next    = ish_reg;
      ifirst_next = ifirst_reg;
      irw_next    = irw_reg;
      ioe_next    = ioe_reg;
      itx_next    = itx_reg;
      i2c_cmd_v   = 1'b0;
      if (!prot_s || bus_stop) begin
         ist_next = I2C_IDLE;
         ioe_next = 1'b0;
      end else if (bus_start) begin
         ist_next    = I2C_RX;
         icnt_next   = '0;
         ifirst_next = 1'b1;
         ioe_next    = 1'b0;
      end else begin
         case (ist_reg)
            I2C_RX: begin
               if (scl_rise) begin
                  ish_next  = {ish_reg[6:0], sda_s};
                  icnt_next = icnt_reg + 4'h1;
               end else if (scl_fall && icnt_reg == 4'(I2C_BYTE)) begin
                  icnt_next = '0;
                  if (!ifirst_reg) begin
                     i2c_cmd_v = 1'b1;
                     ist_next  = I2C_ACK;
                     ioe_next  = 1'b1;
                  end else if (addr_hit) begin
                     ist_next    = I2C_ACK;
                     ioe_next    = 1'b1;
                     ifirst_next = 1'b0;
                     irw_next    = ish_reg[0];
                  end else begin
                     ist_next = I2C_IDLE;
                  end
               end
            end
            I2C_ACK: begin
               if (scl_fall) begin
                  if (irw_reg) begin
                     ist_next = I2C_TX;
                     itx_next = pay_reg;
                     ioe_next = ~pay_reg[23];
                  end else begin
                     ist_next = I2C_RX;
                     ioe_next = 1'b0;
                  end
               end
            end
            I2C_TX: begin
               if (scl_rise) begin
                  icnt_next = icnt_reg + 4'h1;
               end else if (scl_fall && icnt_reg == 4'(I2C_BYTE)) begin
                  ist_next  = I2C_RACK;
                  ioe_next  = 1'b0;
                  icnt_next = '0;
               end else if (scl_fall) begin
                  itx_next = {itx_reg[22:0], 1'b0};
                  ioe_next = ~itx_reg[22];
               end
            end
            I2C_RACK: begin
               if (scl_rise && sda_s) begin
                  ist_next = I2C_IDLE;
               end else if (scl_fall) begin
                  ist_next = I2C_TX;
                  itx_next = {itx_reg[22:0], 1'b0};
                  ioe_next = ~itx_reg[22];
               end
            end
            default: begin
               ist_next = I2C_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ist_reg    <= I2C_IDLE;
         icnt_reg   <= '0;
         ish_reg    <= '0;
         ifirst_reg <= 1'b0;
         irw_reg    <= 1'b0;
         ioe_reg    <= 1'b0;
         itx_reg    <= '0;
      end else begin
         ist_reg    <= ist_next;
         icnt_reg   <= icnt_next;
         ish_reg    <= ish_next;
         ifirst_reg <= ifirst_next;
         irw_reg    <= irw_next;
         ioe_reg    <= ioe_next;
         itx_reg    <= itx_next;
      end
   end

   // one command stream from either mode
   assign cmd_v     = i2c_cmd_v | spi_evt;
   assign cmd_byte  = i2c_cmd_v ? ish_reg : scmd_reg;
   assign dec       = cmd_decode(cmd_byte);
   assign cmd_sel   = dec.sel;
   assign conv_done = (conv_reg == CONV_BUSY) && (ccnt_reg == '0);
   assign busy_o       = (conv_reg == CONV_BUSY);
   assign cal_loaded_o = calok_reg;

   // command execution and conversion timing
   always_comb begin
      conv_next   = conv_reg;
      ccnt_next   = ccnt_reg;
      temp_next   = temp_reg;
      bad_next    = bad_reg;
      fresh_next  = fresh_reg;
      calok_next  = calok_reg;
      result_next = result_reg;
      pay_next    = pay_reg;
      cal_next    = cal_reg;
      // runs on the core clock only, whatever the select pin does
      if (conv_done) begin
         conv_next   = CONV_IDLE;
         fresh_next  = 1'b1;
         result_next = temp_reg ? raw_temperature_sample_i
                                : raw_pressure_sample_i;
         if (bad_reg) begin
            result_next = ~result_next;
         end
      end else if (conv_reg == CONV_BUSY) begin
         ccnt_next = ccnt_reg - 15'h0001;
      end
      if (cmd_v) begin
         if (dec.rst) begin
            conv_next  = CONV_IDLE;
            fresh_next = 1'b0;
            bad_next   = 1'b0;
            pay_next   = '0;
            calok_next = 1'b1;
            for (int i = 0; i < CAL_WORDS; i++) begin
               cal_next[i] = CAL_INIT[16*i +: 16];
            end
         end else if (dec.rd) begin
            pay_next = (busy_o || !fresh_reg) ? '0 : result_reg;
            if (busy_o) begin
               bad_next = 1'b1;
            end
            if (!conv_done) begin
               fresh_next = 1'b0;
            end
         end else if (dec.conv) begin
            conv_next = CONV_BUSY;
            ccnt_next = 15'((CONV_BASE << dec.sel) - 1);
            temp_next = dec.temp;
            bad_next  = busy_o;
         end else if (dec.calibration_memory) begin
            pay_next = {cal_reg[dec.sel], 8'h00};
         end
      end
      pub_next = (fresh_next && conv_next == CONV_IDLE) ? result_next : '0;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         conv_reg   <= CONV_IDLE;
         ccnt_reg   <= '0;
         temp_reg   <= 1'b0;
         bad_reg    <= 1'b0;
         fresh_reg  <= 1'b0;
         calok_reg  <= 1'b0;
         result_reg <= '0;
         pay_reg    <= '0;
         pub_reg    <= '0;
         for (int i = 0; i < CAL_WORDS; i++) begin
            cal_reg[i] <= '0;
         end
      end else begin
         conv_reg   <= conv_next;
         ccnt_reg   <= ccnt_next;
         temp_reg   <= temp_next;
         bad_reg    <= bad_next;
         fresh_reg  <= fresh_next;
         calok_reg  <= calok_next;
         result_reg <= result_next;
         pay_reg    <= pay_next;
         pub_reg    <= pub_next;
         cal_reg    <= cal_next;
      end
   end

   // checks on the core clock
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   property p_reset_any;
      cmd_v && dec.rst |=> !busy_o && !fresh_reg && cal_loaded_o;
   endproperty
   a_reset_any: assert property (p_reset_any)
      else $error("reset ignored");
   property p_busy_hold;
      busy_o && ccnt_reg != '0 && !(cmd_v && dec.rst) |=> busy_o;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped");
   property p_conv_end;
      conv_done && !cmd_v |=> !busy_o && fresh_reg;
   endproperty
   a_conv_end: assert property (p_conv_end)
      else $error("no completion");
   property p_read_busy;
      cmd_v && dec.rd && busy_o |=> pay_reg == '0 && bad_reg;
   endproperty
   a_read_busy: assert property (p_read_busy)
      else $error("busy read");
   property p_read_stale;
      cmd_v && dec.rd && !fresh_reg |=> pay_reg == '0;
   endproperty
   a_read_stale: assert property (p_read_stale)
      else $error("stale data");
   property p_read_clear;
      cmd_v && dec.rd && !conv_done |=> !fresh_reg && pub_reg == '0;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("repeat read");
   property p_calibration_memory;
      cmd_v && dec.calibration_memory |=> pay_reg[23:8] == cal_reg[$past(cmd_sel)];
   endproperty
   a_calibration_memory: assert property (p_calibration_memory)
      else $error("wrong word");
   property p_addr_ack;
      ist_reg == I2C_RX && scl_fall && icnt_reg == 4'h8 && ifirst_reg
      && addr_hit |=> ist_reg == I2C_ACK && sda_oe_o;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("no addr ack");
   property p_byte_ack;
      ist_reg == I2C_TX && scl_fall && icnt_reg == 4'h8
      |=> ist_reg == I2C_RACK && !sda_oe_o;
   endproperty
   a_byte_ack: assert property (p_byte_ack)
      else $error("no ack slot");
   property p_tx_msb;
      ist_reg == I2C_ACK && scl_fall && irw_reg && !bus_stop && prot_s
      |=> sda_oe_o == !pay_reg[23];
   endproperty
   a_tx_msb: assert property (p_tx_msb)
      else $error("msb not first");
   property p_undef;
      cmd_v && !(dec.rst || dec.rd || dec.conv || dec.calibration_memory)
      |=> $stable(pay_reg) && $stable(cal_loaded_o);
   endproperty
   a_undef: assert property (p_undef)
      else $error("undefined acted");
endmodule
`default_nettype wire

// file: sensor_serial_command_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_serial_command_port_tb;
   import sensor_cmd_pkg::*;
   localparam logic [127:0] CAL_TB =
      128'h7E57_C0EF_4A5B_3C2D_1E0F_9876_ABCD_0F1E;
   localparam logic [7:0] CODES [10] = '{8'h40, 8'h42, 8'h44, 8'h46,
      8'h48, 8'h50, 8'h52, 8'h54, 8'h56, 8'h58};
   localparam logic [7:0] BAD [3] = '{8'h33, 8'h4A, 8'hA1};
   logic        mclk, rst_b, proto, sclk, sel, sdi, sdo, sda, sda_oe;
   logic        busy, cal, nak, sdo_oe, sda_d;
   logic [23:0] pres, temp, rd;
   int          mismatches, checks;

   sensor_serial_command_port #(.CONV_BASE(8), .CAL_INIT(CAL_TB))
   sensor_serial_command_port_i (.mclk_i(mclk), .rst_b_i(rst_b),
      .sclk_i(sclk), .proto_i2c_i(proto), .select_or_address_pin_i(sel),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sda_i(sda), .sda_o(sda_d),
      .sda_oe_o(sda_oe), .raw_pressure_sample_i(pres),
      .raw_temperature_sample_i(temp), .busy_o(busy),
      .cal_loaded_o(cal));

   host_bus_model host_bus_model_i (.mclk_i(mclk), .sda_oe_i(sda_oe),
      .sdo_i(sdo), .sclk_o(sclk), .sel_o(sel), .sdi_o(sdi), .sda_o(sda));

   // core clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] e);
      checks++;
      if (got !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask

   function automatic logic [15:0] cal_w(input int a);
      return CAL_TB[16*a +: 16];
   endfunction

   function automatic logic [23:0] conv_exp(input logic [7:0] c);
      return c[4] ? temp : pres;
   endfunction

   task automatic results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic hw(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic rst(input logic p);
      rst_b = 1'b0;
      proto = p;
      host_bus_model_i.strap(1'b1, p);
      hw(2);
      rst_b = 1'b1;
      hw(3);
   endtask

   task automatic wait_idle;
      for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge mclk);
      #1;
      chk(24'(busy), 24'h0);
   endtask

   // stuck run is cut short
   initial begin
      #2000000;
      mismatches++;
      results();
   end

   // main sequence: four-wire first, then two-wire after a second reset
   initial begin
      mismatches = 0;
      checks = 0;
      pres = '0;
      temp = '0;
      void'($urandom(32'h006b));
      rst(1'b0);
      chk(24'(cal), 24'h0);
      chk(24'(sdo_oe), 24'h0);
      fork
         host_bus_model_i.spi(8'hA2, 32, rd);
         #300 chk(24'(sdo_oe), 24'h1);
      join
      chk(rd, 24'h0);
      host_bus_model_i.spi(CMD_RESET, 8, rd);
      hw(1);
      chk(24'(cal), 24'h1);
      for (int a = 0; a < CAL_WORDS; a++) begin
         host_bus_model_i.spi(8'hA0 | 8'(a << 1), 32, rd);
         chk(rd, {cal_w(a), 8'h00});
      end
      foreach (CODES[i]) begin
         pres = 24'($urandom);
         temp = 24'($urandom);
         host_bus_model_i.spi(CODES[i], 8, rd);
         hw(2);
         chk(24'(busy), 24'h1);
         wait_idle();
         host_bus_model_i.spi(CMD_ADC_READ, 32, rd);
         chk(rd, conv_exp(CODES[i]));
         host_bus_model_i.spi(CMD_ADC_READ, 32, rd);
         chk(rd, 24'h0);
      end
      host_bus_model_i.spi(8'h48, 8, rd);
      host_bus_model_i.spi(CMD_ADC_READ, 32, rd);
      chk(rd, 24'h0);
      wait_idle();
      host_bus_model_i.spi(CMD_ADC_READ, 32, rd);
      chk(rd, ~pres);
      host_bus_model_i.spi(8'h58, 8, rd);
      host_bus_model_i.spi(CMD_RESET, 8, rd);
      hw(2);
      chk(24'(busy), 24'h0);
      host_bus_model_i.spi(CMD_ADC_READ, 32, rd);
      chk(rd, 24'h0);
      foreach (BAD[i]) begin
         host_bus_model_i.spi(BAD[i], 8, rd);
         hw(2);
         chk(24'(busy), 24'h0);
      end
      rst(1'b1);
      host_bus_model_i.pulses(9);
      host_bus_model_i.i2c(8'hEC, CMD_RESET, nak, rd);
      chk(24'(nak), 24'h0);
      chk(24'(cal), 24'h1);
      host_bus_model_i.i2c(8'hEE, CMD_RESET, nak, rd);
      chk(24'(nak), 24'h1);
      host_bus_model_i.i2c(8'hEC, 8'hA6, nak, rd);
      host_bus_model_i.i2c(8'hED, 8'h00, nak, rd);
      chk(rd, {cal_w(3), 8'h00});
      host_bus_model_i.strap(1'b0, 1'b1);
      hw(3);
      chk(24'({sda_d, sdo_oe}), 24'h0);
      temp = 24'($urandom);
      host_bus_model_i.i2c(8'hEE, 8'h58, nak, rd);
      chk(24'(nak), 24'h0);
      chk(24'(busy), 24'h1);
      wait_idle();
      host_bus_model_i.i2c(8'hEE, CMD_ADC_READ, nak, rd);
      host_bus_model_i.i2c(8'hEF, 8'h00, nak, rd);
      chk(rd, temp);
      results();
   end
endmodule
`default_nettype wire
